// *** ccsf_pkg.sv ***
//----------------------------------------------------------------------
// ccsf_pkg: constants for the capture/compare status and trigger flags
//----------------------------------------------------------------------
// Purpose: register map, field positions, reset values, encodings
// Assumes: 16-bit register port, word index addressing
// Notes:   shared by ccsf_top and ccsf_top_tb
//
// Behaviour
// RULE_01: writing one to gate arm arms one-shot gating only in modes 01/10; reads zero
// RULE_02: triggered status reads one while timer triggered and running, else zero
// RULE_03: with triggering enabled, writing one to trigger set starts timer; reads zero
// RULE_04: with triggering enabled, writing one to trigger clear cancels trigger; reads zero
// RULE_05: shutdown status is one during shutdown event; software may clear it
// RULE_06: single-edge-compare flag sets on event, stays until software clears it
// RULE_07: capture disable one blocks pin capture events; zero lets them through
// RULE_08: capture overflow flag sets on buffer overflow, stays until software clears
// RULE_09: buffer-not-empty reads one while capture buffer holds data
// RULE_10: period update pending reads one while period copy in progress
// RULE_11: timer-high update pending reads one while upper count copy in progress
// RULE_12: timer-low update pending reads one while lower count copy in progress
// RULE_13: compare-B update pending reads one while compare B copy in progress
// RULE_14: compare-A update pending reads one while compare A copy in progress
// RULE_15: mode 10 falling gate edge sets capture disable; mode 01 rising edge clears it
// RULE_16: mode 00 high gate level enables capture, low level disables it
// RULE_17: triggered mode with output gating holds outputs off until triggered
// RULE_18: update pending bits self-clear once the buffered value is copied

package ccsf_pkg;

  // register word indices
  localparam logic [2:0] CCSF_ADR_STAT_LO  = 3'h0;
  localparam logic [2:0] CCSF_ADR_STAT_HI  = 3'h1;
  localparam logic [2:0] CCSF_ADR_CTRL     = 3'h2;
  localparam logic [2:0] CCSF_ADR_INT_STAT = 3'h3;
  localparam logic [2:0] CCSF_ADR_INT_MASK = 3'h4;

  // status low fields
  localparam int CCSF_B_GATE_ARM  = 10;
  localparam int CCSF_B_TRIG_STAT = 7;
  localparam int CCSF_B_TRIG_SET  = 6;
  localparam int CCSF_B_TRIG_CLR  = 5;
  localparam int CCSF_B_SHUTDOWN  = 4;
  localparam int CCSF_B_SEC_FLAG  = 3;
  localparam int CCSF_B_CAP_DIS   = 2;
  localparam int CCSF_B_CAP_OVF   = 1;
  localparam int CCSF_B_BUF_NE    = 0;

  // control fields
  localparam int CCSF_B_TRIG_EN   = 0;
  localparam int CCSF_B_GSM_LO    = 1;
  localparam int CCSF_B_OE_TRIG   = 3;

  // interrupt event bits
  localparam int CCSF_NUM_EVT     = 4;
  localparam int CCSF_E_SHUTDOWN  = 0;
  localparam int CCSF_E_SEC       = 1;
  localparam int CCSF_E_OVF       = 2;
  localparam int CCSF_E_CAPTURE   = 3;

  // number of buffered update targets: period, tmr hi, tmr lo, cmp B, cmp A
  localparam int CCSF_NUM_UPD     = 5;

  // gating mode encodings
  localparam logic [1:0] CCSF_GSM_LEVEL = 2'h0;
  localparam logic [1:0] CCSF_GSM_RISE  = 2'h1;
  localparam logic [1:0] CCSF_GSM_FALL  = 2'h2;

  // reset values
  localparam logic [15:0] CCSF_RST_DATA = 16'h0000;

  typedef enum logic [0:0] {
    CCSF_GATE_IDLE  = 1'b0,
    CCSF_GATE_ARMED = 1'b1
  } ccsf_gate_e;

endpackage : ccsf_pkg

// *** ccsf_top.sv ***
//----------------------------------------------------------------------
// ccsf_top: status flags, trigger requests and capture gating
//----------------------------------------------------------------------
// Purpose: status/trigger register logic of a capture/compare timer
// Assumes: one clock, synchronous active-low reset, 16-bit reg port
// Notes:   capture and gate pins are synchronised by two flops
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/100ps

module ccsf_top (
  // clock and reset
  input  wire logic                                clk,
  input  wire logic                                rst_b,
  // register port
  input  wire logic [2:0]                          reg_addr,
  input  wire logic [15:0]                         reg_wdata,
  input  wire logic                                reg_wr,
  input  wire logic                                reg_rd,
  output logic      [15:0]                         reg_rdata,
  // pins
  input  wire logic                                capture_input_pin,
  input  wire logic                                gate_source,
  // timer core side
  input  wire logic                                ext_trigger,
  input  wire logic                                shutdown_active,
  input  wire logic                                single_edge_cmp_evt,
  input  wire logic                                capture_fifo_ovf,
  input  wire logic                                capture_buffer_not_empty,
  input  wire logic [ccsf_pkg::CCSF_NUM_UPD-1:0]   upd_request,
  input  wire logic                                upd_sync,
  output logic                                     capture_event,
  output logic                                     timer_run,
  output logic                                     output_drive_en,
  output logic      [ccsf_pkg::CCSF_NUM_UPD-1:0]   upd_load,
  // interrupt
  output logic                                     irq
);
  import ccsf_pkg::*;

  //--------------------------------------------------------------------
  // state
  //--------------------------------------------------------------------
  typedef struct packed {
    logic                      trig_en;
    logic [1:0]                gsm;
    logic                      oe_trig;
    logic                      trig;
    logic                      shutdown;
    logic                      sec_flag;
    logic                      cap_dis;
    logic                      cap_ovf;
    ccsf_gate_e                gate_st;
    logic [CCSF_NUM_UPD-1:0]   pend;
    logic [CCSF_NUM_EVT-1:0]   int_st;
    logic [CCSF_NUM_EVT-1:0]   int_mask;
    logic                      cap_s1;
    logic                      cap_s2;
    logic                      cap_prev;
    logic                      gat_s1;
    logic                      gat_s2;
    logic                      gat_prev;
    logic [15:0]               rdata;
    logic                      irq;
    logic                      cap_evt;
    logic                      run;
    logic                      drv_en;
    logic [CCSF_NUM_UPD-1:0]   load;
  } ccsf_state_s;

  ccsf_state_s s_q;
  ccsf_state_s s_d;

  // decoded writes, arm permission, pin and gate edges, events and read views
  logic                      wr_lo;
  logic                      wr_ctrl;
  logic                      wr_ist;
  logic                      wr_imsk;
  logic                      arm_ok;
  logic                      cap_edge;
  logic                      gate_rise;
  logic                      gate_fall;
  logic [CCSF_NUM_EVT-1:0]   evt;
  logic [15:0]               stat_lo;
  logic [15:0]               stat_hi;

  //--------------------------------------------------------------------
  // next-state logic
  //--------------------------------------------------------------------
  // one process computes every register's next value
  always_comb begin
    s_d       = s_q;
    wr_lo     = reg_wr && (reg_addr == CCSF_ADR_STAT_LO);
    wr_ctrl   = reg_wr && (reg_addr == CCSF_ADR_CTRL);
    wr_ist    = reg_wr && (reg_addr == CCSF_ADR_INT_STAT);
    wr_imsk   = reg_wr && (reg_addr == CCSF_ADR_INT_MASK);
    arm_ok    = (s_q.gsm == CCSF_GSM_RISE) || (s_q.gsm == CCSF_GSM_FALL);
    cap_edge  = s_q.cap_s2 && !s_q.cap_prev;
    gate_rise = s_q.gat_s2 && !s_q.gat_prev;
    gate_fall = !s_q.gat_s2 && s_q.gat_prev;

    // two-flop synchronisers, then edge history
    s_d.cap_s1   = capture_input_pin;
    s_d.cap_s2   = s_q.cap_s1;
    s_d.cap_prev = s_q.cap_s2;
    s_d.gat_s1   = gate_source;
    s_d.gat_s2   = s_q.gat_s1;
    s_d.gat_prev = s_q.gat_s2;

    // control register
    if (wr_ctrl) begin
      s_d.trig_en = reg_wdata[CCSF_B_TRIG_EN];
      s_d.gsm     = reg_wdata[CCSF_B_GSM_LO +: 2];
      s_d.oe_trig = reg_wdata[CCSF_B_OE_TRIG];
    end

    // trigger: clear request first so set requests win
    if (!s_q.trig_en) begin
      s_d.trig = 1'b0;
    end else begin
      if (wr_lo && reg_wdata[CCSF_B_TRIG_CLR]) begin
        s_d.trig = 1'b0;                                   // RULE_04
      end
      if ((wr_lo && reg_wdata[CCSF_B_TRIG_SET]) || ext_trigger) begin
        s_d.trig = 1'b1;                                   // RULE_03
      end
    end

    // sticky flags: software write-one clears, hardware set wins
    if (wr_lo && reg_wdata[CCSF_B_SHUTDOWN]) begin
      s_d.shutdown = 1'b0;
    end
    if (shutdown_active) begin
      s_d.shutdown = 1'b1;                                 // RULE_05
    end
    if (wr_lo && reg_wdata[CCSF_B_SEC_FLAG]) begin
      s_d.sec_flag = 1'b0;
    end
    if (single_edge_cmp_evt) begin
      s_d.sec_flag = 1'b1;                                 // RULE_06
    end
    if (wr_lo && reg_wdata[CCSF_B_CAP_OVF]) begin
      s_d.cap_ovf = 1'b0;
    end
    if (capture_fifo_ovf) begin
      s_d.cap_ovf = 1'b1;                                  // RULE_08
    end

    // capture disable: software clear, then gating source
    if (wr_lo && reg_wdata[CCSF_B_CAP_DIS]) begin
      s_d.cap_dis = 1'b0;
    end
    case (s_q.gate_st)
      CCSF_GATE_IDLE: begin
        if (wr_lo && reg_wdata[CCSF_B_GATE_ARM] && arm_ok) begin
          s_d.gate_st = CCSF_GATE_ARMED;                   // RULE_01
        end
      end
      CCSF_GATE_ARMED: begin
        if (!arm_ok) begin
          s_d.gate_st = CCSF_GATE_IDLE;
        end else if (s_q.gsm == CCSF_GSM_FALL && gate_fall) begin
          s_d.cap_dis = 1'b1;                              // RULE_15
          s_d.gate_st = CCSF_GATE_IDLE;
        end else if (s_q.gsm == CCSF_GSM_RISE && gate_rise) begin
          s_d.cap_dis = 1'b0;                              // RULE_15
          s_d.gate_st = CCSF_GATE_IDLE;
        end
      end
      default: begin
        s_d.gate_st = CCSF_GATE_IDLE;
      end
    endcase
    if (s_q.gsm == CCSF_GSM_LEVEL) begin
      s_d.cap_dis = !s_q.gat_s2;                           // RULE_16
    end

    // capture event from pin edge unless disabled
    s_d.cap_evt = cap_edge && !s_q.cap_dis;                // RULE_07

    // buffered updates: copy on sync, new request wins
    s_d.load = upd_sync ? s_q.pend : '0;
    if (upd_sync) begin
      s_d.pend = '0;                                       // RULE_18
    end
    s_d.pend = s_d.pend | upd_request;

    // timer run and output gating
    s_d.run    = !s_q.trig_en || s_q.trig;                 // RULE_02
    s_d.drv_en = !(s_q.trig_en && s_q.oe_trig && !s_q.trig); // RULE_17

    // interrupt status and mask
    evt[CCSF_E_SHUTDOWN] = shutdown_active && !s_q.shutdown;
    evt[CCSF_E_SEC]      = single_edge_cmp_evt;
    evt[CCSF_E_OVF]      = capture_fifo_ovf;
    evt[CCSF_E_CAPTURE]  = s_d.cap_evt;
    if (wr_ist) begin
      s_d.int_st = s_q.int_st & ~reg_wdata[CCSF_NUM_EVT-1:0];
    end
    s_d.int_st = s_d.int_st | evt;
    if (wr_imsk) begin
      s_d.int_mask = reg_wdata[CCSF_NUM_EVT-1:0];
    end
    s_d.irq = |(s_q.int_st & s_q.int_mask);

    // read views; request bits always read zero
    stat_lo = CCSF_RST_DATA;
    stat_lo[CCSF_B_TRIG_STAT] = s_q.trig;                  // RULE_02
    stat_lo[CCSF_B_SHUTDOWN]  = s_q.shutdown;
    stat_lo[CCSF_B_SEC_FLAG]  = s_q.sec_flag;
    stat_lo[CCSF_B_CAP_DIS]   = s_q.cap_dis;
    stat_lo[CCSF_B_CAP_OVF]   = s_q.cap_ovf;
    stat_lo[CCSF_B_BUF_NE]    = capture_buffer_not_empty; // RULE_09
    stat_hi = CCSF_RST_DATA;
    stat_hi[CCSF_NUM_UPD-1:0] = s_q.pend;   // RULE_10 RULE_11 RULE_12 RULE_13 RULE_14

    // read data valid only in the cycle after the strobe
    s_d.rdata = CCSF_RST_DATA;
    if (reg_rd) begin
      case (reg_addr)
        CCSF_ADR_STAT_LO:  s_d.rdata = stat_lo;
        CCSF_ADR_STAT_HI:  s_d.rdata = stat_hi;
        CCSF_ADR_CTRL: begin
          s_d.rdata[CCSF_B_TRIG_EN]       = s_q.trig_en;
          s_d.rdata[CCSF_B_GSM_LO +: 2]   = s_q.gsm;
          s_d.rdata[CCSF_B_OE_TRIG]       = s_q.oe_trig;
        end
        CCSF_ADR_INT_STAT: s_d.rdata[CCSF_NUM_EVT-1:0] = s_q.int_st;
        CCSF_ADR_INT_MASK: s_d.rdata[CCSF_NUM_EVT-1:0] = s_q.int_mask;
        default:           s_d.rdata = CCSF_RST_DATA;
      endcase
    end
  end

  //--------------------------------------------------------------------
  // state register
  //--------------------------------------------------------------------
  // synchronous reset to constants
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q         <= '0;
      s_q.run     <= 1'b1;
      s_q.drv_en  <= 1'b1;
      s_q.gate_st <= CCSF_GATE_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign reg_rdata       = s_q.rdata;
  assign irq             = s_q.irq;
  assign capture_event   = s_q.cap_evt;
  assign timer_run       = s_q.run;
  assign output_drive_en = s_q.drv_en;
  assign upd_load        = s_q.load;

  //--------------------------------------------------------------------
  // assertions
  //--------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  arm_reads_zero_a: assert property (                         // RULE_01
    reg_rd && reg_addr == CCSF_ADR_STAT_LO |=> !reg_rdata[CCSF_B_GATE_ARM]
      && !reg_rdata[CCSF_B_TRIG_SET] && !reg_rdata[CCSF_B_TRIG_CLR])
    else $error("request bits read nonzero");

  arm_mode_gate_a: assert property (                          // RULE_01
    s_q.gate_st == CCSF_GATE_IDLE && !arm_ok |=> s_q.gate_st == CCSF_GATE_IDLE)
    else $error("gate armed outside one-shot modes");

  trig_set_run_a: assert property (                           // RULE_03
    s_q.trig_en && wr_lo && reg_wdata[CCSF_B_TRIG_SET] && !wr_ctrl
      |=> ##1 timer_run)
    else $error("trigger set did not start timer");

  trig_clr_stop_a: assert property (                          // RULE_04
    s_q.trig_en && wr_lo && reg_wdata[CCSF_B_TRIG_CLR] && !reg_wdata[CCSF_B_TRIG_SET]
      && !ext_trigger && !wr_ctrl |=> ##1 !timer_run)
    else $error("trigger clear did not stop timer");

  shutdown_sets_a: assert property (                          // RULE_05
    shutdown_active |=> s_q.shutdown)
    else $error("shutdown status not set");

  sec_sticky_a: assert property (                             // RULE_06
    s_q.sec_flag && !(wr_lo && reg_wdata[CCSF_B_SEC_FLAG]) |=> s_q.sec_flag)
    else $error("compare flag lost without clear");

  cap_block_a: assert property (                              // RULE_07
    s_q.cap_dis |=> !capture_event)
    else $error("capture event while disabled");

  ovf_set_a: assert property (                                // RULE_08
    capture_fifo_ovf |=> s_q.cap_ovf)
    else $error("overflow flag not set");

  gate_fall_a: assert property (                              // RULE_15
    s_q.gate_st == CCSF_GATE_ARMED && s_q.gsm == CCSF_GSM_FALL && gate_fall
      |=> s_q.cap_dis && s_q.gate_st == CCSF_GATE_IDLE)
    else $error("falling gate edge missed");

  gate_level_a: assert property (                             // RULE_16
    s_q.gsm == CCSF_GSM_LEVEL && !wr_ctrl |=> s_q.cap_dis == !$past(s_q.gat_s2))
    else $error("level gating mismatch");

  drive_hold_a: assert property (                             // RULE_17
    s_q.trig_en && s_q.oe_trig && !s_q.trig |=> !output_drive_en)
    else $error("outputs driven before trigger");

  pend_clear_a: assert property (                             // RULE_18
    upd_sync && upd_request == '0 |=> s_q.pend == '0 && upd_load == $past(s_q.pend))
    else $error("pending bit not cleared on copy");

  // register views and remaining sticky and gating paths
  trig_stat_view_a: assert property (                         // RULE_02
    reg_rd && reg_addr == CCSF_ADR_STAT_LO |=> reg_rdata[CCSF_B_TRIG_STAT] == $past(s_q.trig))
    else $error("triggered status view mismatch");

  buf_ne_view_a: assert property (                            // RULE_09
    reg_rd && reg_addr == CCSF_ADR_STAT_LO
      |=> reg_rdata[CCSF_B_BUF_NE] == $past(capture_buffer_not_empty))
    else $error("buffer not empty view mismatch");

  pend_set_a: assert property (                               // RULE_10
    upd_request != '0 |=> (s_q.pend & $past(upd_request)) == $past(upd_request))
    else $error("update request not held pending");

  pend_view_a: assert property (                              // RULE_14
    reg_rd && reg_addr == CCSF_ADR_STAT_HI |=> reg_rdata[CCSF_NUM_UPD-1:0] == $past(s_q.pend))
    else $error("pending view mismatch");

  ovf_sticky_a: assert property (                             // RULE_08
    s_q.cap_ovf && !(wr_lo && reg_wdata[CCSF_B_CAP_OVF]) |=> s_q.cap_ovf)
    else $error("overflow flag lost without clear");

  gate_rise_a: assert property (                              // RULE_15
    s_q.gate_st == CCSF_GATE_ARMED && s_q.gsm == CCSF_GSM_RISE && gate_rise
      |=> !s_q.cap_dis && s_q.gate_st == CCSF_GATE_IDLE)
    else $error("rising gate edge missed");

  cov_trig_c:  cover property (wr_lo && reg_wdata[CCSF_B_TRIG_SET] ##2 timer_run);
  cov_gate_c:  cover property (s_q.gate_st == CCSF_GATE_ARMED ##[1:20] gate_rise);
  cov_irq_c:   cover property (capture_event ##[1:3] irq);
  cov_load_c:  cover property (upd_request != '0 ##[1:20] upd_load != '0);

endmodule : ccsf_top

// *** ccsf_top_tb.sv ***
// Purpose: self-checking bench for the status, trigger and gating flags
// Assumes: one 125 MHz clock, synchronous active-low reset, 1-cycle read latency
// Notes:   every scenario drives the ports itself and judges the answers
`timescale 1ns/100ps

module ccsf_top_tb;
  import ccsf_pkg::*;

  logic                    clk;
  logic                    rst_b;
  logic [2:0]              reg_addr;
  logic [15:0]             reg_wdata;
  logic                    reg_wr;
  logic                    reg_rd;
  logic [15:0]             reg_rdata;
  logic                    cap_pin;
  logic                    gate;
  logic                    ext_trig;
  logic                    shut;
  logic                    sec_evt;
  logic                    ovf;
  logic                    bne;
  logic [CCSF_NUM_UPD-1:0] upd_req;
  logic                    usync;
  logic                    capture_event;
  logic                    timer_run;
  logic                    output_drive_en;
  logic [CCSF_NUM_UPD-1:0] upd_load;
  logic                    irq;
  int                      n_fail;
  int                      compares;

  ccsf_top dut_u (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .capture_input_pin(cap_pin), .gate_source(gate), .ext_trigger(ext_trig),
    .shutdown_active(shut), .single_edge_cmp_evt(sec_evt), .capture_fifo_ovf(ovf),
    .capture_buffer_not_empty(bne), .upd_request(upd_req), .upd_sync(usync),
    .capture_event(capture_event), .timer_run(timer_run),
    .output_drive_en(output_drive_en), .upd_load(upd_load), .irq(irq)
  );

  // 8 ns clock
  always #4 clk = ~clk;

  //--------------------------------------------------------------------
  // shared tasks
  //--------------------------------------------------------------------
  task automatic complete_run;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rdchk(input logic [2:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, exp);
    @(posedge clk);
  endtask : rdchk

  // one synced pin rise, then count capture pulses
  task automatic cap_rise(input logic [15:0] exp);
    logic [15:0] c;
    c = 16'h0000;
    @(posedge clk);
    cap_pin <= 1'b1;
    repeat (8) begin
      @(posedge clk);
      #1;
      if (capture_event === 1'b1) c++;
    end
    @(posedge clk);
    cap_pin <= 1'b0;
    tick(3);
    chk(c, exp);
  endtask : cap_rise

  //--------------------------------------------------------------------
  // scenarios
  //--------------------------------------------------------------------
  task automatic t_reset;
    chk({14'h0, timer_run, output_drive_en}, 16'h0003);
    rdchk(CCSF_ADR_STAT_LO, 16'h0000);
    rdchk(CCSF_ADR_STAT_HI, 16'h0000);
    rdchk(3'h5, 16'h0000);
  endtask : t_reset

  task automatic t_trigger;
    wr(CCSF_ADR_CTRL, 16'h0009);
    tick(3);
    chk({14'h0, timer_run, output_drive_en}, 16'h0000);
    wr(CCSF_ADR_STAT_LO, 16'h0040);
    tick(3);
    chk({14'h0, timer_run, output_drive_en}, 16'h0003);
    rdchk(CCSF_ADR_STAT_LO, 16'h0080);
    wr(CCSF_ADR_STAT_LO, 16'h0020);
    tick(3);
    chk({14'h0, timer_run, output_drive_en}, 16'h0000);
    rdchk(CCSF_ADR_STAT_LO, 16'h0000);
    @(posedge clk);
    ext_trig <= 1'b1;
    @(posedge clk);
    ext_trig <= 1'b0;
    tick(3);
    rdchk(CCSF_ADR_STAT_LO, 16'h0080);
    wr(CCSF_ADR_CTRL, 16'h0000);
    wr(CCSF_ADR_STAT_LO, 16'h0040);
    tick(3);
    rdchk(CCSF_ADR_STAT_LO, 16'h0000);
    chk({14'h0, timer_run, output_drive_en}, 16'h0003);
  endtask : t_trigger

  task automatic t_flags;
    wr(CCSF_ADR_INT_MASK, 16'h0007);
    @(posedge clk);
    shut    <= 1'b1;
    sec_evt <= 1'b1;
    ovf     <= 1'b1;
    bne     <= 1'b1;
    @(posedge clk);
    shut    <= 1'b0;
    sec_evt <= 1'b0;
    ovf     <= 1'b0;
    tick(3);
    rdchk(CCSF_ADR_STAT_LO, 16'h001B);
    chk({15'h0, irq}, 16'h0001);
    wr(CCSF_ADR_INT_MASK, 16'h0000);
    tick(2);
    chk({15'h0, irq}, 16'h0000);
    wr(CCSF_ADR_INT_MASK, 16'h0007);
    tick(2);
    chk({15'h0, irq}, 16'h0001);
    wr(CCSF_ADR_STAT_LO, 16'h001A);
    rdchk(CCSF_ADR_STAT_LO, 16'h0001);
    bne <= 1'b0;
    rdchk(CCSF_ADR_STAT_LO, 16'h0000);
    wr(CCSF_ADR_INT_STAT, 16'h000F);
    tick(2);
    chk({15'h0, irq}, 16'h0000);
  endtask : t_flags

  task automatic t_gating;
    cap_rise(16'h0001);
    gate <= 1'b0;
    tick(4);
    rdchk(CCSF_ADR_STAT_LO, 16'h0004);
    cap_rise(16'h0000);
    gate <= 1'b1;
    tick(4);
    rdchk(CCSF_ADR_STAT_LO, 16'h0000);
    // arm while level mode is refused
    wr(CCSF_ADR_STAT_LO, 16'h0400);
    wr(CCSF_ADR_CTRL, 16'h0004);
    gate <= 1'b0;
    tick(4);
    rdchk(CCSF_ADR_STAT_LO, 16'h0000);
    gate <= 1'b1;
    tick(4);
    wr(CCSF_ADR_STAT_LO, 16'h0400);
    rdchk(CCSF_ADR_STAT_LO, 16'h0000);
    gate <= 1'b0;
    tick(4);
    rdchk(CCSF_ADR_STAT_LO, 16'h0004);
    cap_rise(16'h0000);
    wr(CCSF_ADR_CTRL, 16'h0002);
    wr(CCSF_ADR_STAT_LO, 16'h0400);
    gate <= 1'b1;
    tick(4);
    rdchk(CCSF_ADR_STAT_LO, 16'h0000);
    cap_rise(16'h0001);
    rdchk(CCSF_ADR_INT_STAT, 16'h0008);
    rdchk(CCSF_ADR_INT_MASK, 16'h0007);
    rdchk(CCSF_ADR_CTRL, 16'h0002);
    wr(CCSF_ADR_INT_STAT, 16'h000F);
  endtask : t_gating

  task automatic t_update;
    for (int i = 0; i < CCSF_NUM_UPD; i++) begin
      @(posedge clk);
      upd_req <= CCSF_NUM_UPD'(1 << i);
      @(posedge clk);
      upd_req <= '0;
      tick(2);
      rdchk(CCSF_ADR_STAT_HI, 16'(1 << i));
      @(posedge clk);
      usync <= 1'b1;
      @(posedge clk);
      usync <= 1'b0;
      #1;
      chk({11'h0, upd_load}, 16'(1 << i));
      rdchk(CCSF_ADR_STAT_HI, 16'h0000);
    end
  endtask : t_update

  //--------------------------------------------------------------------
  // main sequence and watchdog
  //--------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cap_pin = 1'b0;
    gate = 1'b1;
    ext_trig = 1'b0;
    shut = 1'b0;
    sec_evt = 1'b0;
    ovf = 1'b0;
    bne = 1'b0;
    upd_req = '0;
    usync = 1'b0;
    n_fail = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    tick(4);
    t_reset();
    t_trigger();
    t_flags();
    t_gating();
    t_update();
    complete_run();
  end

  // cut a hang short well beyond the expected run
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    complete_run();
  end

endmodule : ccsf_top_tb
